// ---- hw/acps_axil_slave.sv ----
`timescale 1ns/1ps
module acps_axil_slave (
   // Clock and reset
   input  wire logic        i_clock,
   input  wire logic        i_reset_n,
   // Write channels
   input  wire logic [7:0]  i_awaddr,
   input  wire logic        i_awvalid,
   output logic             o_awready,
   input  wire logic [31:0] i_wdata,
   input  wire logic [3:0]  i_wstrb,
   input  wire logic        i_wvalid,
   output logic             o_wready,
   output logic [1:0]       o_bresp,
   output logic             o_bvalid,
   input  wire logic        i_bready,
   // Read channels
   input  wire logic [7:0]  i_araddr,
   input  wire logic        i_arvalid,
   output logic             o_arready,
   output logic [31:0]      o_rdata,
   output logic [1:0]       o_rresp,
   output logic             o_rvalid,
   input  wire logic        i_rready,
   // Register side
   output logic             o_wr_fire,
   output logic [7:0]       o_wr_addr,
   output logic [31:0]      o_wr_data,
   output logic [3:0]       o_wr_strb,
   output logic             o_rd_fire,
   input  wire logic [31:0] i_rdata
);
   import acps_pkg::*;

   typedef struct packed {
      logic        aw_full;
      logic [7:0]  aw_addr;
      logic        w_full;
      logic [31:0] w_data;
      logic [3:0]  w_strb;
      logic        awready;
      logic        wready;
      logic        arready;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
      logic        wr_fire;
   } acps_axi_type;

   acps_axi_type r_reg, r_next;

   always_comb begin
      r_next = r_reg;
      r_next.wr_fire = 1'b0;
      o_rd_fire = i_arvalid && r_reg.arready;
      if (i_awvalid && r_reg.awready) begin
         r_next.aw_full = 1'b1;
         r_next.aw_addr = i_awaddr;
      end
      if (i_wvalid && r_reg.wready) begin
         r_next.w_full = 1'b1;
         r_next.w_data = i_wdata;
         r_next.w_strb = i_wstrb;
      end
      if (r_reg.bvalid && i_bready) begin
         r_next.bvalid = 1'b0;
      end
      if (r_reg.aw_full && r_reg.w_full && !r_reg.bvalid) begin
         r_next.aw_full = 1'b0;
         r_next.w_full = 1'b0;
         r_next.bvalid = 1'b1;
         r_next.bresp = reg_hit(r_reg.aw_addr) ? RESP_OKAY : RESP_SLVERR;
         r_next.wr_fire = reg_hit(r_reg.aw_addr);
      end
      if (r_reg.rvalid && i_rready) begin
         r_next.rvalid = 1'b0;
      end
      if (o_rd_fire) begin
         r_next.rvalid = 1'b1;
         r_next.rdata = i_rdata;
         r_next.rresp = reg_hit(i_araddr) ? RESP_OKAY : RESP_SLVERR;
      end
      r_next.awready = !r_next.aw_full;
      r_next.wready = !r_next.w_full;
      r_next.arready = !r_next.rvalid;
   end

   always_ff @(posedge i_clock) begin
      if (!i_reset_n) begin
         r_reg <= '0;
      end else begin
         r_reg <= r_next;
      end
   end

   assign o_awready = r_reg.awready;
   assign o_wready = r_reg.wready;
   assign o_bvalid = r_reg.bvalid;
   assign o_bresp = r_reg.bresp;
   assign o_arready = r_reg.arready;
   assign o_rvalid = r_reg.rvalid;
   assign o_rdata = r_reg.rdata;
   assign o_rresp = r_reg.rresp;
   assign o_wr_fire = r_reg.wr_fire;
   assign o_wr_addr = r_reg.aw_addr;
   assign o_wr_data = r_reg.w_data;
   assign o_wr_strb = r_reg.w_strb;
endmodule : acps_axil_slave

// ---- hw/acps_odr_timer.sv ----
`timescale 1ns/1ps
module acps_odr_timer #(
   parameter int DECIM_W = 12,
   parameter int CNT_W   = 20
) (
   // Clock and reset
   input  wire logic               i_clock,
   input  wire logic               i_reset_n,
   // Control
   input  wire logic               i_restart,
   input  wire logic [DECIM_W-1:0] i_decim,
   input  wire logic               i_halver,
   // Period tick
   output logic                    o_tick
);
   import acps_pkg::*;

   typedef struct packed {
      logic [CNT_W-1:0] cnt;
      logic             tick;
   } acps_tmr_type;

   acps_tmr_type r_reg, r_next;
   logic [CNT_W-1:0] len;

   always_comb begin
      len = (CNT_W'({i_decim, MOD_SHIFT'(0)}) << i_halver) - CNT_W'(1);
      r_next = r_reg;
      r_next.tick = 1'b0;
      if (i_restart) begin
         r_next.cnt = '0;
      end else if (r_reg.cnt >= len) begin
         r_next.cnt = '0;
         r_next.tick = 1'b1;
      end else begin
         r_next.cnt = r_reg.cnt + CNT_W'(1);
      end
   end

   always_ff @(posedge i_clock) begin
      if (!i_reset_n) begin
         r_reg <= '0;
      end else begin
         r_reg <= r_next;
      end
   end

   assign o_tick = r_reg.tick;
endmodule : acps_odr_timer

// ---- hw/acps_pkg.sv ----
package acps_pkg;

   // ****************************************
   // Register map and fields
   // ****************************************
   localparam int          AXI_AW       = 8;
   localparam logic [7:0]  CTRL_OFS     = 8'h00;
   localparam logic [7:0]  DECIM_OFS    = 8'h04;
   localparam logic [7:0]  STATUS_OFS   = 8'h08;
   localparam logic [7:0]  DATA_OFS     = 8'h0C;
   localparam logic [7:0]  OFF0_OFS     = 8'h10;
   localparam logic [7:0]  GAIN0_OFS    = 8'h14;
   localparam logic [7:0]  OFF1_OFS     = 8'h18;
   localparam logic [7:0]  GAIN1_OFS    = 8'h1C;
   localparam int          F_MODE_LOW   = 0;
   localparam int          F_MODE_HIGH  = 1;
   localparam int          F_SYNC_HOLD  = 2;
   localparam int          F_POWER_DOWN = 3;
   localparam int          F_CLKO_DIS   = 4;
   localparam int          F_HALVER     = 5;
   localparam int          F_BIPOLAR    = 6;
   localparam int          F_CHANNEL    = 7;
   localparam logic [7:0]  CTRL_RESET   = 8'h04;
   localparam logic [11:0] DECIM_RESET  = 12'h187;
   localparam logic [15:0] OFF_RESET    = 16'h0000;
   localparam logic [15:0] GAIN_RESET   = 16'h8000;
   localparam logic [15:0] MIDSCALE     = 16'h8000;
   localparam logic [1:0]  RESP_OKAY    = 2'h0;
   localparam logic [1:0]  RESP_SLVERR  = 2'h2;

   // ****************************************
   // Timing, in output periods and input clocks
   // ****************************************
   localparam logic [3:0]  SELF_CAL_PER  = 4'h6;
   localparam logic [3:0]  SELF_MID_PER  = 4'h3;
   localparam logic [3:0]  SELF_CONV_PER = 4'h3;
   localparam logic [3:0]  SYS_CAL_PER   = 4'h3;
   localparam logic [3:0]  SYS_CONV_PER  = 4'h1;
   localparam logic [3:0]  START_PER     = 4'h3;
   localparam logic [10:0] PIPE_CYCLES   = 11'h7D0;
   localparam logic [6:0]  MOD_LAST      = 7'h7F;
   localparam logic [6:0]  MOD_SHIFT     = 7'h07;

   // ****************************************
   // Types
   // ****************************************
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000, ST_ARM = 3'b001, ST_CAL = 3'b011,
      ST_CONV = 3'b010, ST_RUN = 3'b110, ST_PDN = 3'b100
   } acps_state_type;

   function automatic logic reg_hit(input logic [7:0] a);
      reg_hit = (a[1:0] == 2'h0) && (a <= GAIN1_OFS);
   endfunction : reg_hit

   function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] d,
                                         input logic [3:0] s);
      for (int i = 0; i < 4; i++) begin
         o[i*8 +: 8] = s[i] ? d[i*8 +: 8] : o[i*8 +: 8];
      end
      merge = o;
   endfunction : merge

endpackage : acps_pkg

// ---- hw/acps_sequencer.sv ----
// Local design decisions: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
module acps_sequencer (
   // Clock and reset
   input  wire logic                       I_CLOCK,
   input  wire logic                       I_RESET_N,
   // AXI4-Lite write
   input  wire logic [acps_pkg::AXI_AW-1:0] I_AWADDR,
   input  wire logic                       I_AWVALID,
   output logic                            O_AWREADY,
   input  wire logic [31:0]                I_WDATA,
   input  wire logic [3:0]                 I_WSTRB,
   input  wire logic                       I_WVALID,
   output logic                            O_WREADY,
   output logic [1:0]                      O_BRESP,
   output logic                            O_BVALID,
   input  wire logic                       I_BREADY,
   // AXI4-Lite read
   input  wire logic [acps_pkg::AXI_AW-1:0] I_ARADDR,
   input  wire logic                       I_ARVALID,
   output logic                            O_ARREADY,
   output logic [31:0]                     O_RDATA,
   output logic [1:0]                      O_RRESP,
   output logic                            O_RVALID,
   input  wire logic                       I_RREADY,
   // Converter side
   input  wire logic [15:0]                I_SAMPLE,
   input  wire logic                       I_EXT_CRYSTAL,
   output logic                            O_DATA_READY_N,
   output logic                            O_MOD_RESET,
   output logic [1:0]                      O_CAL_INPUT,
   output logic                            O_CHANNEL,
   output logic                            O_OSC_ENABLE,
   output logic                            O_CLOCK_OUTPUT_EN
);
   import acps_pkg::*;

   // ****************************************
   // State
   // ****************************************
   typedef struct packed {
      acps_state_type  state;
      logic [1:0]      cal;
      logic            data_ready_n;
      logic [7:0]      ctrl;
      logic [11:0]     decim;
      logic [15:0]     data;
      logic [1:0][15:0] off;
      logic [1:0][15:0] gain;
      logic [15:0]     zero;
      logic [3:0]      per;
      logic [10:0]     pipe;
      logic [6:0]      mod;
      logic            ext_s1;
      logic            ext_s2;
      logic            mod_rst;
      logic [1:0]      cal_in;
      logic            osc_en;
      logic            clko_en;
   } acps_seq_type;

   localparam logic [1:0] CAL_SELF = 2'b01;
   localparam logic [1:0] IN_ANALOG = 2'b00;
   localparam logic [1:0] IN_SHORT = 2'b01;
   localparam logic [1:0] IN_REF = 2'b10;

   acps_seq_type r_reg, r_next;
   logic        wr_fire;
   logic [7:0]  wr_addr;
   logic [31:0] wr_data;
   logic [3:0]  wr_strb;
   logic        rd_fire;
   logic [31:0] rdata;
   logic        tick;
   logic        restart;
   logic        chan;
   logic        bip;
   logic [1:0]  mode;

   // ****************************************
   // Helpers
   // ****************************************
   function automatic logic [15:0] calc_gain(input logic [15:0] fs, input logic [15:0] zs,
                                             input logic b);
      logic [15:0] span;
      span = fs - zs;
      calc_gain = b ? {span[14:0], 1'b0} : span;
   endfunction : calc_gain

   function automatic logic [15:0] calc_off(input logic [15:0] zs, input logic b);
      calc_off = b ? zs - MIDSCALE : zs;
   endfunction : calc_off

   // ****************************************
   // Bus slave and period timer
   // ****************************************
   acps_axil_slave u_axi (
      .i_clock   (I_CLOCK),
      .i_reset_n (I_RESET_N),
      .i_awaddr  (I_AWADDR),
      .i_awvalid (I_AWVALID),
      .o_awready (O_AWREADY),
      .i_wdata   (I_WDATA),
      .i_wstrb   (I_WSTRB),
      .i_wvalid  (I_WVALID),
      .o_wready  (O_WREADY),
      .o_bresp   (O_BRESP),
      .o_bvalid  (O_BVALID),
      .i_bready  (I_BREADY),
      .i_araddr  (I_ARADDR),
      .i_arvalid (I_ARVALID),
      .o_arready (O_ARREADY),
      .o_rdata   (O_RDATA),
      .o_rresp   (O_RRESP),
      .o_rvalid  (O_RVALID),
      .i_rready  (I_RREADY),
      .o_wr_fire (wr_fire),
      .o_wr_addr (wr_addr),
      .o_wr_data (wr_data),
      .o_wr_strb (wr_strb),
      .o_rd_fire (rd_fire),
      .i_rdata   (rdata)
   );

   acps_odr_timer #(
      .DECIM_W (12),
      .CNT_W   (20)
   ) u_timer (
      .i_clock   (I_CLOCK),
      .i_reset_n (I_RESET_N),
      .i_restart (restart),
      .i_decim   (r_reg.decim),
      .i_halver  (r_reg.ctrl[F_HALVER]),
      .o_tick    (tick)
   );

   // ****************************************
   // Read mux
   // ****************************************
   always_comb begin
      rdata = 32'h0000_0000;
      case (I_ARADDR)
         CTRL_OFS:   rdata = {24'h00_0000, r_reg.ctrl};
         DECIM_OFS:  rdata = {20'h0_0000, r_reg.decim};
         STATUS_OFS: rdata = {23'h00_0000, r_reg.ext_s2, 1'b0, r_reg.state,
                              1'b0, r_reg.state == ST_PDN,
                              r_reg.state inside {ST_ARM, ST_CAL, ST_CONV},
                              r_reg.data_ready_n};
         DATA_OFS:   rdata = {16'h0000, r_reg.data};
         OFF0_OFS:   rdata = {16'h0000, r_reg.off[0]};
         GAIN0_OFS:  rdata = {16'h0000, r_reg.gain[0]};
         OFF1_OFS:   rdata = {16'h0000, r_reg.off[1]};
         GAIN1_OFS:  rdata = {16'h0000, r_reg.gain[1]};
         default:    rdata = 32'h0000_0000;
      endcase
   end

   // ****************************************
   // Sequencer
   // ****************************************
   always_comb begin
      r_next = r_reg;
      restart = 1'b0;
      chan = r_reg.ctrl[F_CHANNEL];
      bip = r_reg.ctrl[F_BIPOLAR];
      mode = {r_reg.ctrl[F_MODE_HIGH], r_reg.ctrl[F_MODE_LOW]};
      r_next.mod = r_reg.mod + 7'h01;
      r_next.ext_s1 = I_EXT_CRYSTAL;
      r_next.ext_s2 = r_reg.ext_s1;
      // Software writes; while powered down only these, a DATA read (data ready high), I_EXT_CRYSTAL (STATUS bit 8) and the mod counter alter registers
      if (wr_fire) begin
         case (wr_addr)
            CTRL_OFS:  r_next.ctrl = 8'(merge({24'h00_0000, r_reg.ctrl}, wr_data, wr_strb));
            DECIM_OFS: r_next.decim = 12'(merge({20'h0_0000, r_reg.decim}, wr_data, wr_strb));
            OFF0_OFS:  r_next.off[0] = 16'(merge({16'h0000, r_reg.off[0]}, wr_data, wr_strb));
            GAIN0_OFS: r_next.gain[0] = 16'(merge({16'h0000, r_reg.gain[0]}, wr_data, wr_strb));
            OFF1_OFS:  r_next.off[1] = 16'(merge({16'h0000, r_reg.off[1]}, wr_data, wr_strb));
            GAIN1_OFS: r_next.gain[1] = 16'(merge({16'h0000, r_reg.gain[1]}, wr_data, wr_strb));
            default:   r_next.ctrl = r_next.ctrl;
         endcase
      end
      if (rd_fire && I_ARADDR == DATA_OFS) begin
         r_next.data_ready_n = 1'b1;
      end
      case (r_reg.state)
         ST_IDLE: begin
            restart = 1'b1;
            r_next.mod_rst = 1'b1;
            if (r_reg.ctrl[F_POWER_DOWN]) begin
               r_next.state = ST_PDN;
            end else if (!r_reg.ctrl[F_SYNC_HOLD]) begin
               r_next.mod_rst = 1'b0;
               if (mode != 2'b00) begin
                  r_next.state = ST_ARM;
               end else begin
                  r_next.state = ST_CONV;
                  r_next.cal = 2'b00;
                  r_next.pipe = PIPE_CYCLES;
                  r_next.per = START_PER;
               end
            end
         end
         ST_ARM: begin
            restart = 1'b1;
            if (r_reg.data_ready_n || r_reg.mod == MOD_LAST) begin
               r_next.data_ready_n = 1'b1;
               r_next.state = ST_CAL;
               r_next.cal = mode;
               r_next.per = (mode == CAL_SELF) ? SELF_CAL_PER : SYS_CAL_PER;
               r_next.cal_in = (mode == CAL_SELF) ? IN_SHORT : IN_ANALOG;
            end
         end
         ST_CAL: begin
            if (tick) begin
               r_next.per = r_reg.per - 4'h1;
               if (r_reg.cal == CAL_SELF && r_reg.per == SELF_MID_PER + 4'h1) begin
                  r_next.zero = I_SAMPLE;
                  r_next.cal_in = IN_REF;
               end
               if (r_reg.per == 4'h1) begin
                  r_next.ctrl[F_MODE_HIGH] = 1'b0;
                  r_next.ctrl[F_MODE_LOW] = 1'b0;
                  r_next.cal_in = IN_ANALOG;
                  r_next.state = ST_CONV;
                  r_next.pipe = 11'h000;
                  r_next.per = (r_reg.cal == CAL_SELF) ? SELF_CONV_PER : SYS_CONV_PER;
                  case (r_reg.cal)
                     2'b01: begin
                        r_next.off[chan] = calc_off(r_reg.zero, bip);
                        r_next.gain[chan] = calc_gain(I_SAMPLE, r_reg.zero, bip);
                     end
                     2'b10: r_next.off[chan] = calc_off(I_SAMPLE, bip);
                     2'b11: r_next.gain[chan] = calc_gain(I_SAMPLE,
                                                r_reg.off[chan] + (bip ? MIDSCALE : 16'h0000),
                                                bip);
                     default: r_next.cal = 2'b00;
                  endcase
               end
            end
         end
         ST_CONV: begin
            if (r_reg.pipe != 11'h000) begin
               restart = 1'b1;
               r_next.pipe = r_reg.pipe - 11'h001;
            end else if (tick) begin
               r_next.per = r_reg.per - 4'h1;
               if (r_reg.per == 4'h1) begin
                  r_next.data = I_SAMPLE;
                  r_next.data_ready_n = 1'b0;
                  r_next.state = ST_RUN;
                  r_next.cal = 2'b00;
               end
            end
         end
         ST_RUN: begin
            if (tick) begin
               r_next.data = I_SAMPLE;
               r_next.data_ready_n = 1'b0;
            end
            if (wr_fire && wr_addr == CTRL_OFS
                && r_next.ctrl[F_MODE_HIGH:F_MODE_LOW] != 2'b00) begin
               r_next.state = ST_ARM;
            end
         end
         ST_PDN: begin
            restart = 1'b1;
            if (!r_reg.ctrl[F_POWER_DOWN]) begin
               if (r_reg.ctrl[F_SYNC_HOLD]) begin
                  r_next.state = ST_IDLE;
               end else begin
                  r_next.state = ST_CONV;
                  r_next.mod_rst = 1'b0;
                  r_next.pipe = PIPE_CYCLES;
                  r_next.per = START_PER;
               end
            end
         end
         default: r_next.state = ST_IDLE;
      endcase
      if (r_reg.state != ST_IDLE && r_reg.state != ST_PDN) begin
         if (r_reg.ctrl[F_POWER_DOWN]) begin
            r_next.state = ST_PDN;
            r_next.cal_in = IN_ANALOG;
         end else if (r_reg.ctrl[F_SYNC_HOLD]) begin
            r_next.state = ST_IDLE;
            r_next.mod_rst = 1'b1;
            r_next.cal_in = IN_ANALOG;
         end
      end
      r_next.osc_en = !r_next.ext_s2 && r_next.state != ST_PDN;
      r_next.clko_en = r_next.ext_s2 && !r_next.ctrl[F_CLKO_DIS];
   end

   always_ff @(posedge I_CLOCK) begin
      if (!I_RESET_N) begin
         r_reg <= '0;
         r_reg.state <= ST_IDLE;
         r_reg.data_ready_n <= 1'b1;
         r_reg.ctrl <= CTRL_RESET;
         r_reg.decim <= DECIM_RESET;
         r_reg.off <= {OFF_RESET, OFF_RESET};
         r_reg.gain <= {GAIN_RESET, GAIN_RESET};
         r_reg.mod_rst <= 1'b1;
      end else begin
         r_reg <= r_next;
      end
   end

   assign O_DATA_READY_N = r_reg.data_ready_n;
   assign O_MOD_RESET = r_reg.mod_rst;
   assign O_CAL_INPUT = r_reg.cal_in;
   assign O_CHANNEL = r_reg.ctrl[F_CHANNEL];
   assign O_OSC_ENABLE = r_reg.osc_en;
   assign O_CLOCK_OUTPUT_EN = r_reg.clko_en;
endmodule : acps_sequencer

// ---- sim/acps_afe_model.sv ----
`timescale 1ns/1ps
module acps_afe_model (
   // Clock
   input  wire logic        i_clock,
   // Converter control
   input  wire logic [1:0]  i_cal_input,
   input  wire logic        i_mod_reset,
   input  wire logic [15:0] i_level,
   // Filter output
   output logic      [15:0] o_sample
);
   // ****************************************
   // Filter word per selected input
   // ****************************************
   always_ff @(posedge i_clock) begin
      if (i_mod_reset) begin
         o_sample <= {~o_sample[15:1], o_sample[15] === 1'b0};
      end else begin
         case (i_cal_input)
            2'h1:    o_sample <= 16'h0100;
            2'h2:    o_sample <= 16'hF000;
            default: o_sample <= i_level;
         endcase
      end
   end
endmodule : acps_afe_model

// ---- sim/acps_sequencer_sva.sv ----
`timescale 1ns/1ps
module acps_sequencer_sva (
   // Clock and reset
   input wire logic        I_CLOCK,
   input wire logic        I_RESET_N,
   // Bus handshakes
   input wire logic        I_ARVALID,
   input wire logic        O_ARREADY,
   input wire logic        O_RVALID,
   input wire logic        I_RREADY,
   input wire logic [31:0] O_RDATA,
   input wire logic        I_AWVALID,
   input wire logic        O_AWREADY,
   input wire logic        O_BVALID,
   input wire logic        I_BREADY,
   input wire logic [1:0]  O_BRESP,
   // Converter side
   input wire logic        O_DATA_READY_N,
   input wire logic        O_MOD_RESET,
   input wire logic [1:0]  O_CAL_INPUT
);
   // ****************************************
   // Bus and sequencing checks
   // ****************************************
   default clocking cb @(posedge I_CLOCK); endclocking
   default disable iff (!I_RESET_N);
   chk_rd_answer: assert property (I_ARVALID && O_ARREADY |=> O_RVALID && !O_ARREADY)
      else $error("read answer not one cycle after take");
   chk_rd_hold: assert property (O_RVALID && !I_RREADY |=> O_RVALID && $stable(O_RDATA))
      else $error("read answer dropped or changed");
   chk_wr_hold: assert property (O_BVALID && !I_BREADY |=> O_BVALID && $stable(O_BRESP))
      else $error("write answer dropped or changed");
   chk_aw_block: assert property (I_AWVALID && O_AWREADY |=> !O_AWREADY)
      else $error("second address taken before write issued");
   chk_resp_code: assert property (O_BVALID |-> O_BRESP == 2'h0 || O_BRESP == 2'h2)
      else $error("illegal write response");
   chk_cal_busy: assert property (O_CAL_INPUT != 2'h0 |-> O_DATA_READY_N)
      else $error("data ready low during calibration");
   chk_cal_run: assert property (O_CAL_INPUT != 2'h0 |-> !O_MOD_RESET)
      else $error("calibration while modulator held");
   chk_result_conv: assert property ($fell(O_DATA_READY_N) |-> O_CAL_INPUT == 2'h0)
      else $error("result flagged while calibrating");
endmodule : acps_sequencer_sva

// ---- sim/acps_sequencer_tb_top.sv ----
`timescale 1ns/1ps
module acps_sequencer_tb_top;
   import acps_pkg::*;
   logic        clk = 1'b0, rst_n = 1'b0, xtal = 1'b0;
   logic        awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0, rry = 1'b0;
   logic [7:0]  awa = 8'h00, ara = 8'h00;
   logic [31:0] wd = 32'h0, rdat;
   logic [3:0]  ws = 4'hF;
   logic [15:0] lvl = 16'h9000, smp;
   logic [1:0]  br, rr, cin;
   logic        awr, wr, bv, arr, rv, drn, mrs, chn, osc, cko;
   int          miscompares = 0, samples_checked = 0, cyc = 0, n;
   int          per [3] = '{9, 4, 4};
   logic [7:0]  cmd [3] = '{8'h01, 8'hC2, 8'hC3};
   always #5 clk = ~clk;
   acps_sequencer i_acps_sequencer (.I_CLOCK(clk), .I_RESET_N(rst_n), .I_AWADDR(awa),
      .I_AWVALID(awv), .O_AWREADY(awr), .I_WDATA(wd), .I_WSTRB(ws), .I_WVALID(wv),
      .O_WREADY(wr), .O_BRESP(br), .O_BVALID(bv), .I_BREADY(bry), .I_ARADDR(ara),
      .I_ARVALID(arv), .O_ARREADY(arr), .O_RDATA(rdat), .O_RRESP(rr), .O_RVALID(rv),
      .I_RREADY(rry), .I_SAMPLE(smp), .I_EXT_CRYSTAL(xtal), .O_DATA_READY_N(drn),
      .O_MOD_RESET(mrs), .O_CAL_INPUT(cin), .O_CHANNEL(chn), .O_OSC_ENABLE(osc),
      .O_CLOCK_OUTPUT_EN(cko));
   acps_afe_model i_acps_afe_model (.i_clock(clk), .i_cal_input(cin), .i_mod_reset(mrs),
      .i_level(lvl), .o_sample(smp));
   // ****************************************
   // Access and compare tasks
   // ****************************************
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         miscompares++;
         $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic wr_reg(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      @(posedge clk);
      awa <= a;
      wd <= d;
      awv <= 1'b1;
      wv <= 1'b1;
      bry <= 1'b1;
      do begin
         @(posedge clk);
         if (awr) awv <= 1'b0;
         if (wr) wv <= 1'b0;
      end while (!bv);
      bry <= 1'b0;
      check(br, er);
   endtask : wr_reg
   task automatic rd_reg(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
      @(posedge clk);
      ara <= a;
      arv <= 1'b1;
      rry <= 1'b1;
      do begin
         @(posedge clk);
         if (arr) arv <= 1'b0;
      end while (!rv);
      rry <= 1'b0;
      check(rdat, e);
      check(rr, er);
   endtask : rd_reg
   task automatic wait_drn(input logic lv, inout int c);
      while (drn !== lv) begin
         @(posedge clk);
         c++;
      end
   endtask : wait_drn
   task automatic summarize();
      $display("checks %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : summarize
   // ****************************************
   // Tests
   // ****************************************
   initial begin
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      rd_reg(CTRL_OFS, 32'h4, RESP_OKAY);
      rd_reg(DECIM_OFS, 32'h187, RESP_OKAY);
      rd_reg(GAIN1_OFS, 32'h8000, RESP_OKAY);
      rd_reg(8'h20, 32'h0, RESP_SLVERR);
      wr_reg(8'h22, 32'hFF, RESP_SLVERR);
      wr_reg(DECIM_OFS, 32'h1, RESP_OKAY);
      $display("test reset done");
      foreach (cmd[i]) begin
         wr_reg(CTRL_OFS, {24'h0, cmd[i] | 8'h04}, RESP_OKAY);
         repeat (2) @(posedge clk);
         check(mrs, 1'b1);
         wr_reg(CTRL_OFS, {24'h0, cmd[i]}, RESP_OKAY);
         check(chn, cmd[i][7]);
         n = 0;
         wait_drn(1'b1, n);
         wait_drn(1'b0, n);
         check(32'(n >= per[i] * 128 - 4 && n <= per[i] * 128 + 140), 32'h1);
         rd_reg(CTRL_OFS, {24'h0, cmd[i] & 8'hFC}, RESP_OKAY);
         rd_reg(DATA_OFS, {16'h0, lvl}, RESP_OKAY);
         check(drn, 1'b1);
         if (i == 0) rd_reg(GAIN0_OFS, 32'hEF00, RESP_OKAY);
         if (i == 1) rd_reg(OFF1_OFS, 32'h1000, RESP_OKAY);
      end
      rd_reg(OFF0_OFS, 32'h0100, RESP_OKAY);
      $display("test calibration done");
      n = 0;
      wait_drn(1'b0, n);
      wr_reg(CTRL_OFS, 32'hC8, RESP_OKAY);
      repeat (300) @(posedge clk);
      check(drn, 1'b0);
      check(osc, 1'b0);
      rd_reg(DECIM_OFS, 32'h1, RESP_OKAY);
      rd_reg(DATA_OFS, {16'h0, lvl}, RESP_OKAY);
      xtal <= 1'b1;
      repeat (300) @(posedge clk);
      check(drn, 1'b1);
      check(cko, 1'b1);
      rd_reg(STATUS_OFS, 32'h145, RESP_OKAY);
      wr_reg(CTRL_OFS, 32'hC0, RESP_OKAY);
      n = 0;
      wait_drn(1'b0, n);
      check(32'(n >= 2000 + 3 * 128 - 4 && n <= 2000 + 3 * 128 + 8), 32'h1);
      $display("test power-down done");
      summarize();
   end
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         miscompares++;
         summarize();
      end
   end
endmodule : acps_sequencer_tb_top
bind acps_sequencer acps_sequencer_sva i_acps_sequencer_sva (.I_CLOCK(I_CLOCK),
   .I_RESET_N(I_RESET_N), .I_ARVALID(I_ARVALID), .O_ARREADY(O_ARREADY),
   .O_RVALID(O_RVALID), .I_RREADY(I_RREADY), .O_RDATA(O_RDATA), .I_AWVALID(I_AWVALID),
   .O_AWREADY(O_AWREADY), .O_BVALID(O_BVALID), .I_BREADY(I_BREADY), .O_BRESP(O_BRESP),
   .O_DATA_READY_N(O_DATA_READY_N), .O_MOD_RESET(O_MOD_RESET), .O_CAL_INPUT(O_CAL_INPUT));
